// file: src/i2c_status_mask.sv
// Status flags, holding registers and slave address mask of an I2C controller.
// Assumes bus-side events arrive as one-cycle pulses from logic on ref_clk.
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Start or Repeated Start detected last sets the start flag; Stop clears it.
// - After a slave address byte, direction flag is 1 for read, 0 for write.
// - Loading a received byte into the receive holding register sets receive-full.
// - A software read of the receive holding register clears receive-full.
// - Software write to transmit holding sets transmit-full; transmission done clears it.
// - Ten-bit mask: a 1 excludes that address bit from comparison, 0 requires match.
// - Upper six mask bits read zero; mask resets to zero for exact matching.
// - New byte while receive holding still full sets overflow; only software clears it.
// - Transmit holding write while busy fails, sets write collision; software clears it.
// - Stop detected last sets the stop flag; Start or Repeated Start clears it.
module i2c_status_mask (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [i2c_status_pkg::WB_AW-1:0]  wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [i2c_status_pkg::WB_DW-1:0]  wb_dat_i,
    output logic      [i2c_status_pkg::WB_DW-1:0]  wb_dat_o,
    output logic                                   wb_ack_o,
    input  wire logic                              start_det,
    input  wire logic                              stop_det,
    input  wire logic                              addr_done,
    input  wire logic                              addr_rw,
    input  wire logic                              rx_byte_valid,
    input  wire logic [i2c_status_pkg::BYTE_W-1:0] rx_byte,
    input  wire logic                              tx_done,
    input  wire logic                              module_busy,
    input  wire logic                              addr_check,
    input  wire logic [i2c_status_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [i2c_status_pkg::ADDR_W-1:0] own_addr,
    output logic                                   addr_match,
    output logic      [i2c_status_pkg::BYTE_W-1:0] tx_data,
    output logic                                   tx_valid,
    input  wire logic                              tx_ready
);
    import i2c_status_pkg::*;

    logic              start_flag_r;
    logic              stop_flag_r;
    logic              rw_flag_r;
    logic              rx_buffer_full_r;
    logic              tx_buffer_full_r;
    logic              rx_overflow_flag_r;
    logic              tx_write_collision_r;
    logic [ADDR_W-1:0] address_bit_mask_r;
    logic [BYTE_W-1:0] rx_holding_register_r;
    logic [ADDR_W-1:0] bit_diff;
    logic              buf_in_ready;
    logic              bus_req;
    logic              bus_wr;
    logic              bus_rd;
    logic              sel_st_wr;
    logic              sel_mask_wr;
    logic              sel_tx_wr;
    logic              sel_rx_rd;
    logic              tx_wr_ok;
    logic              tx_wr_fail;
    logic              rx_load;
    logic [REG_W-1:0]  status_word;
    logic [WB_DW-1:0]  rd_nxt;

    // Bus request is served once, in the cycle before ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;
    assign bus_rd  = bus_req && !wb_we_i;

    always_comb begin
        sel_st_wr   = 1'b0;
        sel_mask_wr = 1'b0;
        sel_tx_wr   = 1'b0;
        sel_rx_rd   = 1'b0;
        if (wb_adr_i == OFS_STATUS) begin
            sel_st_wr = bus_wr && wb_sel_i[0];
        end else if (wb_adr_i == OFS_MASK) begin
            sel_mask_wr = bus_wr;
        end else if (wb_adr_i == OFS_TX_HOLD) begin
            sel_tx_wr = bus_wr && wb_sel_i[0];
        end else if (wb_adr_i == OFS_RX_HOLD) begin
            sel_rx_rd = bus_rd;
        end
    end

    // Transmit write fails while the shifter is busy or the buffer has no room
    assign tx_wr_fail = sel_tx_wr && (module_busy || !buf_in_ready);
    assign tx_wr_ok   = sel_tx_wr && !tx_wr_fail;
    // A byte arriving while the holding register is full is dropped, unless a read comes in the same cycle
    assign rx_load    = rx_byte_valid && !rx_buffer_full_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        status_word           = '0;
        status_word[ST_TBF]   = tx_buffer_full_r;
        status_word[ST_RBF]   = rx_buffer_full_r;
        status_word[ST_RW]    = rw_flag_r;
        status_word[ST_START] = start_flag_r;
        status_word[ST_STOP]  = stop_flag_r;
        status_word[ST_OVF]   = rx_overflow_flag_r;
        status_word[ST_COL]   = tx_write_collision_r;
        rd_nxt                = DAT_RST;
        if (wb_adr_i == OFS_STATUS) begin
            rd_nxt = {{(WB_DW-REG_W){1'b0}}, status_word};
        end else if (wb_adr_i == OFS_MASK) begin
            rd_nxt = {{(WB_DW-ADDR_W){1'b0}}, address_bit_mask_r};
        end else if (wb_adr_i == OFS_RX_HOLD) begin
            rd_nxt = {{(WB_DW-BYTE_W){1'b0}}, rx_holding_register_r};
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= DAT_RST;
        end else if (bus_rd) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // Start and Stop flags track the last bus condition; Start wins a tie
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            start_flag_r <= 1'b0;
            stop_flag_r  <= 1'b0;
        end else if (start_det) begin
            start_flag_r <= 1'b1;
            stop_flag_r  <= 1'b0;
        end else if (stop_det) begin
            start_flag_r <= 1'b0;
            stop_flag_r  <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rw_flag_r <= 1'b0;
        end else if (addr_done) begin
            rw_flag_r <= addr_rw;
        end
    end

    // Receive holding register and its full flag; a new byte wins over a read
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_holding_register_r <= BYTE_RST;
        end else if (rx_load || (rx_byte_valid && sel_rx_rd)) begin
            rx_holding_register_r <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_buffer_full_r <= 1'b0;
        end else if (rx_byte_valid && (!rx_buffer_full_r || sel_rx_rd)) begin
            rx_buffer_full_r <= 1'b1;
        end else if (sel_rx_rd) begin
            rx_buffer_full_r <= 1'b0;
        end
    end

    // Overflow: hardware set wins over a software clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_overflow_flag_r <= 1'b0;
        end else if (rx_byte_valid && rx_buffer_full_r && !sel_rx_rd) begin
            rx_overflow_flag_r <= 1'b1;
        end else if (sel_st_wr && !wb_dat_i[ST_OVF]) begin
            rx_overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_write_collision_r <= 1'b0;
        end else if (tx_wr_fail) begin
            tx_write_collision_r <= 1'b1;
        end else if (sel_st_wr && !wb_dat_i[ST_COL]) begin
            tx_write_collision_r <= 1'b0;
        end
    end

    // Transmit-full: an accepted write wins over completion
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_buffer_full_r <= 1'b0;
        end else if (tx_wr_ok) begin
            tx_buffer_full_r <= 1'b1;
        end else if (tx_done) begin
            tx_buffer_full_r <= 1'b0;
        end
    end

    tx_skid_buffer u_tx_buf (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_data   (wb_dat_i[BYTE_W-1:0]),
        .in_valid  (tx_wr_ok),
        .in_ready  (buf_in_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // Mask register; upper byte lane carries mask bits 9 and 8
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            address_bit_mask_r <= MASK_RST;
        end else if (sel_mask_wr) begin
            if (wb_sel_i[0]) begin
                address_bit_mask_r[BYTE_W-1:0] <= wb_dat_i[BYTE_W-1:0];
            end
            if (wb_sel_i[1]) begin
                address_bit_mask_r[ADDR_W-1:BYTE_W] <= wb_dat_i[ADDR_W-1:BYTE_W];
            end
        end
    end

    // Per-bit compare, skipped where the mask bit is set
    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_cmp
            assign bit_diff[gi] = (addr_in[gi] ^ own_addr[gi]) & !address_bit_mask_r[gi];
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            addr_match <= 1'b0;
        end else if (addr_check) begin
            addr_match <= (bit_diff == '0);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_tx_accept;
        tx_wr_ok;
    endsequence

    sequence s_tx_finish;
        tx_done && !tx_wr_ok;
    endsequence

    sequence s_tbf_up;
        tx_buffer_full_r;
    endsequence

    // Register bus
    AST_WB_ACK: assert property (s_req |=> s_ack_pulse)
        else $error("Wishbone ack not a one-cycle answer");
    AST_RD_STATUS: assert property (s_req ##0 (!wb_we_i && wb_adr_i == OFS_STATUS) |=>
        wb_dat_o[ST_TBF] == $past(tx_buffer_full_r))
        else $error("Status read does not show transmit full");

    // Last bus condition
    AST_START_LAST: assert property (start_det |=> start_flag_r && !stop_flag_r)
        else $error("Start flag wrong after start");
    AST_STOP_LAST: assert property (stop_det && !start_det |=> stop_flag_r && !start_flag_r)
        else $error("Stop flag wrong after stop");
    AST_START_KEEP: assert property (!start_det && !stop_det |=>
        $stable(start_flag_r) && $stable(stop_flag_r))
        else $error("Start or stop flag changed without a condition");

    // Transfer direction
    AST_DIR: assert property (addr_done |=> rw_flag_r == $past(addr_rw))
        else $error("Direction flag does not follow address byte");
    AST_DIR_KEEP: assert property (!addr_done |=> $stable(rw_flag_r))
        else $error("Direction flag changed without an address byte");

    // Receive holding register
    AST_RBF_SET: assert property (rx_load |=> rx_buffer_full_r && rx_holding_register_r == $past(rx_byte))
        else $error("Received byte not loaded");
    AST_RBF_TIE: assert property (sel_rx_rd && rx_byte_valid |=>
        rx_buffer_full_r && rx_holding_register_r == $past(rx_byte))
        else $error("Byte arriving with a read not kept");
    AST_RBF_CLR: assert property (sel_rx_rd && !rx_byte_valid ##1 wb_ack_o |-> !rx_buffer_full_r)
        else $error("Receive full not cleared by read");
    AST_RBF_KEEP: assert property (rx_buffer_full_r && !sel_rx_rd |=> rx_buffer_full_r)
        else $error("Receive full cleared without a read");

    // Receive overflow
    AST_OVF: assert property (rx_byte_valid && rx_buffer_full_r && !sel_rx_rd |=>
        rx_overflow_flag_r && $stable(rx_holding_register_r))
        else $error("Overflow not flagged or byte overwritten");
    AST_OVF_KEEP: assert property (rx_overflow_flag_r && !sel_st_wr |=> rx_overflow_flag_r)
        else $error("Overflow cleared without software");
    AST_OVF_CLR: assert property (sel_st_wr && !wb_dat_i[ST_OVF] && !rx_byte_valid |=>
        !rx_overflow_flag_r)
        else $error("Overflow not cleared by software");

    // Transmit-full
    AST_TBF: assert property (s_tx_accept |=> s_tbf_up)
        else $error("Transmit full not set by write");
    AST_TBF_CLR: assert property (s_tx_finish |=> !tx_buffer_full_r)
        else $error("Transmit full not cleared after completion");
    AST_TBF_HOLD: assert property (!tx_wr_ok && !tx_done |=> $stable(tx_buffer_full_r))
        else $error("Transmit full changed without cause");

    // Write collision
    AST_COL: assert property (tx_wr_fail |=> tx_write_collision_r)
        else $error("Write collision not flagged");
    AST_COL_DROP: assert property (tx_wr_fail && !tx_valid |=> !tx_valid)
        else $error("Failed transmit write reached the buffer");
    AST_COL_KEEP: assert property (tx_write_collision_r && !sel_st_wr |=> tx_write_collision_r)
        else $error("Write collision cleared without software");
    AST_COL_CLR: assert property (sel_st_wr && !wb_dat_i[ST_COL] |=> !tx_write_collision_r)
        else $error("Write collision not cleared by software");

    // Address mask
    AST_MASK_WR: assert property (sel_mask_wr && wb_sel_i[0] |=>
        address_bit_mask_r[BYTE_W-1:0] == $past(wb_dat_i[BYTE_W-1:0]))
        else $error("Mask low byte not written");
    AST_MATCH: assert property (addr_check |=>
        addr_match == ((($past(addr_in) ^ $past(own_addr)) & ~$past(address_bit_mask_r)) == '0))
        else $error("Masked address match wrong");
    AST_MATCH_KEEP: assert property (!addr_check |=> $stable(addr_match))
        else $error("Address match changed without a check");
    AST_MASK_UPPER: assert property (s_req ##0 (!wb_we_i && wb_adr_i == OFS_MASK) |=>
        wb_dat_o[WB_DW-1:ADDR_W] == '0)
        else $error("Upper mask bits not zero");
    AST_MASK_READ: assert property (s_req ##0 (!wb_we_i && wb_adr_i == OFS_MASK) |=>
        wb_dat_o[ADDR_W-1:0] == $past(address_bit_mask_r))
        else $error("Mask read does not show the mask");
endmodule : i2c_status_mask
`default_nettype wire

// file: include/i2c_status_pkg.sv
// Constants for the I2C status flags and slave address mask block.
// Assumes a 32-bit classic Wishbone register bus and byte-wide bus-side data.
package i2c_status_pkg;
    localparam int WB_AW   = 4;
    localparam int WB_DW   = 32;
    localparam int BYTE_W  = 8;
    localparam int ADDR_W  = 10;
    localparam int REG_W   = 16;

    localparam logic [WB_AW-1:0] OFS_STATUS  = 4'h0;
    localparam logic [WB_AW-1:0] OFS_MASK    = 4'h4;
    localparam logic [WB_AW-1:0] OFS_RX_HOLD = 4'h8;
    localparam logic [WB_AW-1:0] OFS_TX_HOLD = 4'hc;

    localparam int ST_TBF   = 0;
    localparam int ST_RBF   = 1;
    localparam int ST_RW    = 2;
    localparam int ST_START = 3;
    localparam int ST_STOP  = 4;
    localparam int ST_OVF   = 6;
    localparam int ST_COL   = 7;

    localparam logic [ADDR_W-1:0] MASK_RST = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [WB_DW-1:0]  DAT_RST  = 32'h0000_0000;
endpackage : i2c_status_pkg

// file: src/tx_skid_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock shared by filling and draining logic.
`timescale 1ns/10ps
`default_nettype none
module tx_skid_buffer (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic [i2c_status_pkg::BYTE_W-1:0] in_data,
    input  wire logic                              in_valid,
    output logic                                   in_ready,
    output logic      [i2c_status_pkg::BYTE_W-1:0] out_data,
    output logic                                   out_valid,
    input  wire logic                              out_ready
);
    import i2c_status_pkg::*;

    logic [BYTE_W-1:0] skid_data_r;
    logic              skid_valid_r;

    // Room exists while the second entry is empty
    assign in_ready = !skid_valid_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_data     <= BYTE_RST;
            out_valid    <= 1'b0;
            skid_data_r  <= BYTE_RST;
            skid_valid_r <= 1'b0;
        end else if (out_ready || !out_valid) begin
            if (skid_valid_r) begin
                out_data     <= skid_data_r;
                out_valid    <= 1'b1;
                skid_valid_r <= 1'b0;
            end else begin
                out_valid <= in_valid;
                if (in_valid) begin
                    out_data <= in_data;
                end
            end
        end else if (in_valid && !skid_valid_r) begin
            skid_data_r  <= in_data;
            skid_valid_r <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_BUF_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Buffer output changed while stalled");
    AST_BUF_FULL: assert property (out_valid && !out_ready && !in_ready |=> !in_ready)
        else $error("Buffer lost a word while full");
endmodule : tx_skid_buffer
`default_nettype wire

// file: verification/i2c_far_end.sv
// Far-side model of the byte shifter that drains the transmit buffer.
// Assumes tx_data and tx_valid come from the device on ref_clk; stall freezes draining.
`timescale 1ns/10ps
`default_nettype none
module i2c_far_end (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic [i2c_status_pkg::BYTE_W-1:0] tx_data,
    input  wire logic                              tx_valid,
    input  wire logic                              stall,
    output logic                                   tx_ready,
    output logic                                   tx_done
);
    import i2c_status_pkg::*;

    logic [BYTE_W-1:0] got_q [$];

    assign tx_ready = !stall;

    // Takes one byte per handshake and reports it sent on the next cycle
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_done <= 1'b0;
        end else begin
            tx_done <= tx_valid && tx_ready;
            if (tx_valid && tx_ready) begin
                got_q.push_back(tx_data);
            end
        end
    end
endmodule : i2c_far_end
`default_nettype wire

// file: verification/tb_i2c_status_mask.sv
// Self-checking bench for the status flags and address mask block.
// Assumes the far-end model drains the transmit stream; bus events come from here.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_status_mask;
    import i2c_status_pkg::*;

    logic              ref_clk;
    logic              reset;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [WB_AW-1:0]  wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [WB_DW-1:0]  wb_dat_i;
    logic [WB_DW-1:0]  wb_dat_o;
    logic              wb_ack_o;
    logic [4:0]        ev;
    logic              addr_rw;
    logic [BYTE_W-1:0] rx_byte;
    logic              tx_done;
    logic              module_busy;
    logic [ADDR_W-1:0] addr_in;
    logic [ADDR_W-1:0] own_addr;
    logic              addr_match;
    logic [BYTE_W-1:0] tx_data;
    logic              tx_valid;
    logic              tx_ready;
    logic              stall;
    logic [WB_DW-1:0]  q;
    int                fail_count;
    int                n_compared;
    int                n;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    i2c_status_mask i_dut (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_det(ev[3]), .stop_det(ev[2]),
        .addr_done(ev[1]), .addr_rw(addr_rw), .rx_byte_valid(ev[0]), .rx_byte(rx_byte),
        .tx_done(tx_done), .module_busy(module_busy), .addr_check(ev[4]), .addr_in(addr_in),
        .own_addr(own_addr), .addr_match(addr_match), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    i2c_far_end i_far (
        .ref_clk(ref_clk), .reset(reset), .tx_data(tx_data), .tx_valid(tx_valid),
        .stall(stall), .tx_ready(tx_ready), .tx_done(tx_done)
    );

    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic hang(input int k);
        if (k >= 100) begin
            fail_count++;
            $display("[FAIL] %0t wait ran out", $time);
            complete_run();
        end
    endtask : hang

    task automatic chk(input logic [WB_DW-1:0] got, input logic [WB_DW-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle: hold until ack is sampled high, then release
    task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [3:0] s,
                      input logic [WB_DW-1:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        hang(k);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic sts(input logic [WB_DW-1:0] m, input logic [WB_DW-1:0] exp);
        wb(1'b0, OFS_STATUS, 4'hf, DAT_RST);
        chk(q & m, exp);
    endtask : sts

    task automatic pulse(input logic [4:0] v, input logic rw, input logic [BYTE_W-1:0] d);
        @(posedge ref_clk);
        ev      <= v;
        addr_rw <= rw;
        rx_byte <= d;
        @(posedge ref_clk);
        ev <= 5'h00;
    endtask : pulse

    task automatic mchk(input logic [ADDR_W-1:0] a, input logic exp);
        addr_in <= a;
        pulse(5'h10, 1'b0, 8'h00);
        @(posedge ref_clk);
        chk({31'h0, addr_match}, {31'h0, exp});
    endtask : mchk

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, addr_rw, module_busy, stall} = 6'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, ev, rx_byte} = '0;
        addr_in = 10'h000;
        own_addr = 10'h155;
        fail_count = 0;
        n_compared = 0;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        sts(32'hffff_ffff, 32'h0);
        wb(1'b0, OFS_MASK, 4'hf, DAT_RST);
        chk(q, 32'h0);
        wb(1'b1, OFS_MASK, 4'hf, 32'hffff_ffff);
        wb(1'b0, OFS_MASK, 4'hf, DAT_RST);
        chk(q, 32'h3ff);
        wb(1'b1, OFS_MASK, 4'h1, 32'h0);
        wb(1'b0, OFS_MASK, 4'hf, DAT_RST);
        chk(q, 32'h300);
        wb(1'b0, 4'h2, 4'hf, DAT_RST);
        chk(q, 32'h0);
        // Address compare, exact then with bits 9 and 0 masked
        wb(1'b1, OFS_MASK, 4'h3, 32'h0);
        mchk(10'h155, 1'b1);
        mchk(10'h154, 1'b0);
        wb(1'b1, OFS_MASK, 4'h3, 32'h201);
        mchk(10'h354, 1'b1);
        mchk(10'h356, 1'b0);
        // Start, stop and direction flags, start winning a tie
        pulse(5'h08, 1'b0, 8'h00);
        sts(32'h18, 32'h08);
        pulse(5'h04, 1'b0, 8'h00);
        sts(32'h18, 32'h10);
        pulse(5'h0c, 1'b0, 8'h00);
        sts(32'h18, 32'h08);
        pulse(5'h02, 1'b1, 8'h00);
        sts(32'h04, 32'h04);
        pulse(5'h02, 1'b0, 8'h00);
        sts(32'h04, 32'h00);
        // Receive, overflow and software clears
        pulse(5'h01, 1'b0, 8'h5a);
        sts(32'h42, 32'h02);
        pulse(5'h01, 1'b0, 8'hc3);
        sts(32'h42, 32'h42);
        wb(1'b0, OFS_RX_HOLD, 4'hf, DAT_RST);
        chk(q, 32'h5a);
        sts(32'h42, 32'h40);
        wb(1'b1, OFS_STATUS, 4'h1, 32'h40);
        sts(32'h42, 32'h40);
        wb(1'b1, OFS_STATUS, 4'h1, 32'h0);
        sts(32'h42, 32'h00);
        // A byte landing in the same cycle as a read is kept
        pulse(5'h01, 1'b0, 8'h3c);
        fork
            wb(1'b0, OFS_RX_HOLD, 4'hf, DAT_RST);
            pulse(5'h01, 1'b0, 8'h96);
        join
        chk(q, 32'h3c);
        sts(32'h42, 32'h02);
        wb(1'b0, OFS_RX_HOLD, 4'hf, DAT_RST);
        chk(q, 32'h96);
        sts(32'h42, 32'h00);
        // Transmit write while busy fails
        module_busy <= 1'b1;
        wb(1'b1, OFS_TX_HOLD, 4'h1, 32'h77);
        module_busy <= 1'b0;
        sts(32'h81, 32'h80);
        wb(1'b1, OFS_STATUS, 4'h1, 32'h0);
        sts(32'h80, 32'h00);
        // Fill the buffer with the far end stalled, then drain
        stall <= 1'b1;
        wb(1'b1, OFS_TX_HOLD, 4'h1, 32'ha1);
        sts(32'h01, 32'h01);
        chk({23'h0, tx_valid, tx_data}, 32'h1a1);
        wb(1'b1, OFS_TX_HOLD, 4'h1, 32'ha2);
        wb(1'b1, OFS_TX_HOLD, 4'h1, 32'ha3);
        sts(32'h81, 32'h81);
        chk({23'h0, tx_valid, tx_data}, 32'h1a1);
        stall <= 1'b0;
        n = 0;
        while (i_far.got_q.size() < 2 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        hang(n);
        repeat (4) @(posedge ref_clk);
        chk(32'(i_far.got_q.size()), 32'd2);
        chk({24'h0, i_far.got_q[0]}, 32'ha1);
        chk({24'h0, i_far.got_q[1]}, 32'ha2);
        sts(32'h01, 32'h00);
        complete_run();
    end
endmodule : tb_i2c_status_mask
`default_nettype wire
